// file: hdl/touch_wheel_spi_regs.vh
// Constants for the touch wheel serial slave port
`ifndef TOUCH_WHEEL_SPI_REGS_VH
`define TOUCH_WHEEL_SPI_REGS_VH
`define CLK_HZ 25000000
`define FLOAT_MS 20
`define CALIB_MS 520
`define WAKE_US 920
`define SLEEP_US 35
`define PULSE_US 56
`define FLOAT_WAKE_US 400
`define DIAG_NS 250
`define FREE_HZ 17
`define SS_TIMEOUT_MS 1000
`define CLOCKING_MS 15
`define MS_CYC(t) ((t) * (`CLK_HZ / 1000))
`define US_CYC(t) ((t) * (`CLK_HZ / 1000000))
`define NS_CYC(t) (((t) * (`CLK_HZ / 1000000) + 999) / 1000)
`define CMD_NULL 8'h00
`define CMD_CALIB 8'h01
`define CMD_DRIFT 8'h03
`define THR_DEFAULT 6'h0A
`define CALIB_BURSTS 4'hA
`define DRIFT_PER_COUNT 4'hA
`define RESP_TOUCH 7
`define RESP_WHEEL 6
`define RESP_POLERR 1
`define RESP_PROX 0
`endif

// file: hdl/spi_shifter.v
// Byte shifter: samples on rising edge, changes output on falling edge
`timescale 1ns/1ps
module spi_shifter (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Synchronised link
  input wire selActive,
  input wire sckRise,
  input wire sckFall,
  input wire mosiBit,
  // Byte side
  input wire [7:0] loadByte,
  output reg misoBit,
  output reg [7:0] rxByte,
  output reg rxDone
);
  reg [7:0] shiftReg;
  reg [2:0] bitCount;

  always @(posedge clock) begin
    rxDone <= 1'b0;
    if (sys_rst || !selActive) begin
      bitCount <= 3'h0;
      shiftReg <= loadByte;
      misoBit <= loadByte[7];
      if (sys_rst)
        rxByte <= 8'h00;
    end else if (sckRise) begin
      shiftReg <= {shiftReg[6:0], mosiBit};
      bitCount <= bitCount + 3'h1;
      if (bitCount == 3'h7) begin
        rxByte <= {shiftReg[6:0], mosiBit};
        rxDone <= 1'b1;
      end
    end else if (sckFall) begin
      misoBit <= shiftReg[7];
    end
  end
endmodule // spi_shifter

// file: hdl/touch_wheel_spi_slave_port.v
// Serial slave port of a capacitive position sensor
`timescale 1ns/1ps
`include "touch_wheel_spi_regs.vh"
module touch_wheel_spi_slave_port #(
  parameter [27:0] FLOAT_CYC = `MS_CYC(`FLOAT_MS),
  parameter [27:0] CALIB_CYC = `MS_CYC(`CALIB_MS),
  parameter [27:0] FREE_CYC = `CLK_HZ / `FREE_HZ,
  parameter [27:0] TIMEOUT_CYC = `MS_CYC(`SS_TIMEOUT_MS),
  parameter [27:0] CLOCKING_CYC = `MS_CYC(`CLOCKING_MS),
  parameter [27:0] WAKE_CYC = `US_CYC(`WAKE_US),
  parameter [27:0] FLOAT_WAKE_CYC = `US_CYC(`FLOAT_WAKE_US),
  parameter [27:0] BURST_CYC = 28'd2500,
  parameter WHEEL_TYPE = 1'b1
) (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Serial pins
  input wire sck,
  input wire mosi,
  input wire selectNIn,
  output reg selectNOut,
  output reg selectNOe,
  output reg miso,
  output reg misoOe,
  // Host-go line
  output reg hostGo,
  output reg hostGoOe,
  output reg detectOe,
  // Sensor results
  input wire touchIn,
  input wire [6:0] positionIn,
  input wire polarityErr,
  input wire proxIn,
  // Sensor control
  output reg burstStart,
  output reg calibrating,
  output reg driftStep,
  output reg [5:0] proxThreshold,
  output reg [5:0] touchThreshold
);
  localparam DIAG_CYC = `NS_CYC(`DIAG_NS);
  localparam [27:0] SLEEP_CYC = `US_CYC(`SLEEP_US);
  localparam [2:0] ST_FLOAT = 3'h0, ST_CALIB = 3'h1, ST_READY = 3'h2,
    ST_SLEEP = 3'h3, ST_WAKE = 3'h4, ST_BURST = 3'h5, ST_LOWGO = 3'h6;

  reg [1:0] sckSync;
  reg [1:0] mosiSync;
  reg [1:0] selSync;
  reg sckPrev, selPrev;
  reg [2:0] state;
  reg [27:0] timer;
  reg [27:0] clockingTimer;
  reg [27:0] freeTimer;
  reg [3:0] calibLeft, driftCount;
  reg [7:0] response, pendingCmd;
  reg cmdPending;
  reg wakeTrig;
  reg lastWasByte;
  reg sawClock;
  reg [3:0] diagCount;
  wire sckRise, sckFall, selActive, selRise, misoBit, rxDone;
  wire [7:0] rxByte;

  function [7:0] standard_resp;
    input touch;
    input [6:0] pos;
    input perr;
    input prox;
    begin
      if (touch)
        standard_resp = {1'b1, pos};
      else
        standard_resp = {1'b0, WHEEL_TYPE[0], 4'h0, perr, prox};
    end
  endfunction

  assign sckRise = sckSync[1] && !sckPrev;
  assign sckFall = !sckSync[1] && sckPrev;
  assign selActive = !selSync[1] && hostGo;
  assign selRise = selSync[1] && !selPrev;

  spi_shifter shifter (
    .clock(clock),
    .sys_rst(sys_rst),
    .selActive(selActive),
    .sckRise(sckRise),
    .sckFall(sckFall),
    .mosiBit(mosiSync[1]),
    .loadByte(response),
    .misoBit(misoBit),
    .rxByte(rxByte),
    .rxDone(rxDone)
  );

  // Two flops on every pin; only the second is read
  always @(posedge clock) begin
    if (sys_rst) begin
      sckSync <= 2'h3;
      mosiSync <= 2'h0;
      selSync <= 2'h3;
      sckPrev <= 1'b1;
      selPrev <= 1'b1;
    end else begin
      sckSync <= {sckSync[0], sck};
      mosiSync <= {mosiSync[0], mosi};
      selSync <= {selSync[0], selectNIn};
      sckPrev <= sckSync[1];
      selPrev <= selSync[1];
    end
  end

  // Miso only driven inside a byte frame
  always @(posedge clock) begin
    if (sys_rst) begin
      miso <= 1'b1;
      misoOe <= 1'b0;
    end else begin
      miso <= misoBit;
      misoOe <= selActive && !lastWasByte;
    end
  end

  always @(posedge clock) begin
    burstStart <= 1'b0;
    driftStep <= 1'b0;
    if (sys_rst) begin
      state <= ST_FLOAT;
      timer <= 28'h0;
      hostGo <= 1'b0;
      hostGoOe <= 1'b0;
      detectOe <= 1'b0;
      calibrating <= 1'b1;
      calibLeft <= 4'h0;
      driftCount <= 4'h0;
      response <= 8'h00;
      pendingCmd <= `CMD_NULL;
      cmdPending <= 1'b0;
      wakeTrig <= 1'b0;
      lastWasByte <= 1'b0;
      sawClock <= 1'b0;
      clockingTimer <= 28'h0;
      freeTimer <= 28'h0;
      proxThreshold <= `THR_DEFAULT;
      touchThreshold <= `THR_DEFAULT;
      selectNOut <= 1'b1;
      selectNOe <= 1'b0;
      diagCount <= 4'h0;
    end else begin
      timer <= timer + 28'h1;
      if (diagCount != 4'h0)
        diagCount <= diagCount - 4'h1;
      else
        selectNOe <= 1'b0;
      selectNOut <= 1'b0;
      // Guards against a stuck host holding select with no clock edges
      if (sckRise || sckFall)
        clockingTimer <= 28'h0;
      else if (clockingTimer != 28'hFFFFFFF)
        clockingTimer <= clockingTimer + 28'h1;
      // Clear first so a byte ending on deselect still counts
      if (!selActive)
        lastWasByte <= 1'b0;
      if (rxDone) begin
        pendingCmd <= rxByte;
        cmdPending <= 1'b1;
        lastWasByte <= 1'b1;
      end
      case (state)
        ST_FLOAT: begin
          if (timer >= FLOAT_CYC - 28'h1) begin
            hostGoOe <= 1'b1;
            hostGo <= 1'b0;
            timer <= 28'h0;
            state <= ST_CALIB;
          end
        end
        ST_CALIB: begin
          if (timer >= CALIB_CYC - 28'h1) begin
            hostGo <= 1'b1;
            calibrating <= 1'b0;
            // First byte after calibration must already be a valid response
            response <= standard_resp(touchIn, positionIn,
              polarityErr, proxIn);
            detectOe <= 1'b1;
            freeTimer <= 28'h0;
            state <= ST_READY;
          end
        end
        ST_READY: begin
          freeTimer <= freeTimer + 28'h1;
          if (rxDone) begin
            timer <= 28'h0;
            state <= ST_LOWGO;
          end else if (selRise && !selActive) begin
            // Dummy pulse, no clocking
            hostGo <= 1'b0;
            wakeTrig <= 1'b1;
            timer <= 28'h0;
            state <= ST_WAKE;
          end else if (selSync[1] && freeTimer >= FREE_CYC - 28'h1) begin
            freeTimer <= 28'h0;
            hostGo <= 1'b0;
            timer <= 28'h0;
            state <= ST_BURST;
          end
        end
        ST_LOWGO: begin
          // Sleep well inside the allowed gap
          if (timer >= SLEEP_CYC - 28'h1) begin
            hostGo <= 1'b0;
            timer <= 28'h0;
            sawClock <= 1'b0;
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (sckRise || sckFall)
            sawClock <= 1'b1;
          if (selRise) begin
            wakeTrig <= 1'b1;
            hostGoOe <= 1'b0;
            detectOe <= 1'b0;
            selectNOe <= 1'b1;
            // Enable also stands in the cycle that clears it
            diagCount <= DIAG_CYC[3:0] - 4'h1;
            timer <= 28'h0;
            state <= ST_WAKE;
          end else if (sawClock && (sckRise || sckFall)) begin
            wakeTrig <= 1'b0;
            hostGoOe <= 1'b0;
            detectOe <= 1'b0;
            timer <= 28'h0;
            state <= ST_WAKE;
          end else if (timer >= TIMEOUT_CYC - 28'h1) begin
            calibLeft <= `CALIB_BURSTS;
            calibrating <= 1'b1;
            pendingCmd <= `CMD_CALIB;
            cmdPending <= 1'b1;
            wakeTrig <= 1'b1;
            timer <= 28'h0;
            state <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (timer >= FLOAT_WAKE_CYC - 28'h1) begin
            hostGoOe <= 1'b1;
            detectOe <= 1'b1;
          end
          if (timer >= WAKE_CYC - 28'h1) begin
            timer <= 28'h0;
            if (wakeTrig || !hostGoOe) begin
              hostGoOe <= 1'b1;
              detectOe <= 1'b1;
              state <= ST_BURST;
            end else begin
              hostGo <= 1'b1;
              state <= ST_READY;
            end
            if (!wakeTrig) begin
              hostGo <= 1'b1;
              state <= ST_READY;
            end
          end
        end
        ST_BURST: begin
          if (timer == 28'h0) begin
            burstStart <= 1'b1;
            wakeTrig <= 1'b0;
            if (cmdPending) begin
              cmdPending <= 1'b0;
              if (pendingCmd == `CMD_CALIB && calibLeft == 4'h0) begin
                calibLeft <= `CALIB_BURSTS;
                calibrating <= 1'b1;
              end else if (pendingCmd[7:6] == 2'b01) begin
                proxThreshold <= pendingCmd[5:0];
              end else if (pendingCmd[7:6] == 2'b10) begin
                touchThreshold <= pendingCmd[5:0];
              end else if (pendingCmd == `CMD_DRIFT && !touchIn) begin
                if (driftCount == `DRIFT_PER_COUNT - 4'h1) begin
                  driftCount <= 4'h0;
                  driftStep <= 1'b1;
                end else begin
                  driftCount <= driftCount + 4'h1;
                end
              end
            end
          end
          if (timer >= BURST_CYC - 28'h1) begin
            timer <= 28'h0;
            // Latched here so the next byte carries this burst's result
            response <= standard_resp(touchIn, positionIn,
              polarityErr, proxIn);
            if (calibLeft > 4'h1) begin
              calibLeft <= calibLeft - 4'h1;
            end else begin
              calibLeft <= 4'h0;
              calibrating <= 1'b0;
              hostGo <= 1'b1;
              freeTimer <= 28'h0;
              state <= ST_READY;
            end
          end
        end
        default: state <= ST_FLOAT;
      endcase
      // Select held with no clock edge for CLOCKING_CYC cycles sends the port back to ST_CALIB
      if (selActive && clockingTimer == CLOCKING_CYC) begin
        state <= ST_CALIB;
        hostGo <= 1'b0;
        timer <= 28'h0;
      end
    end
  end
endmodule // touch_wheel_spi_slave_port

// file: tb/touch_wheel_spi_slave_port_sva.sv
// Pin-level assertions for the touch wheel serial slave port
`timescale 1ns/1ps
module touch_wheel_spi_slave_port_sva #(
  parameter [27:0] WAKE_CYC = 28'd100,
  parameter [27:0] BURST_CYC = 28'd50
) (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Pins
  input wire sck,
  input wire selectNIn,
  input wire selectNOut,
  input wire selectNOe,
  input wire misoOe,
  input wire hostGo,
  input wire hostGoOe,
  input wire detectOe,
  // Sensor control
  input wire burstStart,
  input wire calibrating,
  input wire [5:0] proxThreshold,
  input wire [5:0] touchThreshold
);
  // Sync lag on the select pin widens the wake window
  localparam int WAKE_LO = WAKE_CYC - 2;
  localparam int WAKE_HI = WAKE_CYC + 10;
  localparam int BURST_HI = BURST_CYC + 4;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_THR_DEFAULT: assert property (
    $fell(sys_rst) |-> proxThreshold == 6'h0A && touchThreshold == 6'h0A)
    else $error("threshold reset value wrong");
  AST_PWRUP_FLOAT: assert property (
    $fell(sys_rst) |-> !hostGoOe && !misoOe) else $error("pins driven");
  AST_MISO_RELEASE: assert property (
    misoOe |-> hostGo && hostGoOe) else $error("data out not released");
  AST_SLEEP_ENTRY: assert property (
    $rose(sck) && hostGo && !selectNIn |-> ##[1:980] !hostGo)
    else $error("no sleep after transfer");
  AST_CAL_READY: assert property (
    $rose(hostGo) |-> !calibrating) else $error("ready in calibration");
  AST_DIAG_LOW: assert property (
    selectNOe |-> !selectNOut) else $error("select pulse not low");
  AST_DIAG_SHORT: assert property (
    $rose(selectNOe) |-> ##[1:7] !selectNOe) else $error("select pulse long");
  AST_WAKE_BURST: assert property (
    $rose(selectNIn) && !hostGo && hostGoOe && !calibrating
    |-> ##[WAKE_LO:WAKE_HI] (burstStart || calibrating))
    else $error("burst not at wake delay");
  AST_BURST_READY: assert property (
    burstStart && !calibrating |-> ##[1:BURST_HI] hostGo && hostGoOe)
    else $error("no ready after burst");
  AST_WAKE_FLOAT: assert property (
    $fell(hostGoOe) |-> ##1 (!hostGoOe && !detectOe) [*6])
    else $error("lines driven too soon after wake");
  cover property (burstStart);
  cover property ($rose(calibrating));
  cover property (selectNOe);
endmodule // touch_wheel_spi_slave_port_sva

// file: tb/host_spi_master.sv
// Host controller model driving the serial link as bus master
`timescale 1ns/1ps
module host_spi_master (
  // Clock
  input wire clock,
  // Serial link
  input wire miso,
  input wire selectNOut,
  input wire selectNOe,
  output reg sck,
  output reg mosi,
  output wire selectNIn
);
  reg selectNHost = 1'b1;
  initial begin
    sck = 1'b1;
    mosi = 1'b1;
  end
  // Pulled-up select: either side may pull it low
  assign selectNIn = (selectNOe && !selectNOut) ? 1'b0 : selectNHost;
  task setSel(input logic lvl);
    selectNHost <= lvl;
  endtask
  task xfer(input logic [7:0] cmd, output logic [7:0] resp);
    integer i;
    begin
      selectNHost <= 1'b0;
      repeat (8) @(posedge clock);
      for (i = 7; i >= 0; i = i - 1) begin
        sck <= 1'b0;
        mosi <= cmd[i];
        // Long low half covers the device's sync lag before sampling
        repeat (5) @(posedge clock);
        sck <= 1'b1;
        resp[i] = miso;
        repeat (3) @(posedge clock);
      end
      // Idle data line flips so a stale bit cannot pass
      mosi <= ~cmd[0];
    end
  endtask
endmodule // host_spi_master

// file: tb/tb_touch_wheel_spi_slave_port.sv
// Testbench for the touch wheel serial slave port
`timescale 1ns/1ps
module tb_touch_wheel_spi_slave_port;
  reg clock = 1'b0;
  reg sys_rst = 1'b1;
  reg touchIn = 1'b0;
  reg [6:0] positionIn = 7'h00;
  reg polarityErr = 1'b1;
  reg proxIn = 1'b1;
  wire sck, mosi, selectNIn, selectNOut, selectNOe, miso, misoOe;
  wire hostGo, hostGoOe, detectOe, burstStart, calibrating, driftStep;
  wire [5:0] proxThreshold;
  wire [5:0] touchThreshold;
  integer fail_count = 0;
  integer cmp_count = 0;
  integer bursts = 0;
  integer drifts = 0;
  integer b;
  integer i;
  reg [7:0] resp;
  always #20 clock = ~clock;
  always @(posedge clock) begin
    if (burstStart === 1'b1) bursts <= bursts + 1;
    if (driftStep === 1'b1) drifts <= drifts + 1;
  end
  touch_wheel_spi_slave_port #(
    .FLOAT_CYC(28'd200), .CALIB_CYC(28'd400), .FREE_CYC(28'd500),
    .WAKE_CYC(28'd100), .BURST_CYC(28'd50)
  ) DUT (
    .clock(clock), .sys_rst(sys_rst), .sck(sck), .mosi(mosi),
    .selectNIn(selectNIn), .selectNOut(selectNOut), .selectNOe(selectNOe),
    .miso(miso), .misoOe(misoOe), .hostGo(hostGo), .hostGoOe(hostGoOe),
    .detectOe(detectOe), .touchIn(touchIn), .positionIn(positionIn),
    .polarityErr(polarityErr), .proxIn(proxIn), .burstStart(burstStart),
    .calibrating(calibrating), .driftStep(driftStep),
    .proxThreshold(proxThreshold), .touchThreshold(touchThreshold)
  );
  host_spi_master host (
    .clock(clock), .miso(miso), .selectNOut(selectNOut),
    .selectNOe(selectNOe), .sck(sck), .mosi(mosi), .selectNIn(selectNIn)
  );
  task check(input string name, input logic [7:0] exp, got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task wait_go(input logic lvl, input integer lim);
    integer n;
    begin
      n = 0;
      while ((hostGo !== lvl || hostGoOe !== 1'b1) && n < lim) begin
        @(posedge clock);
        n = n + 1;
      end
      check("hostGo", {6'h00, 1'b1, lvl}, {6'h00, hostGoOe, hostGo});
    end
  endtask
  // Full command: shift, wait for sleep, raise select, wait for ready
  task cmd(input logic [7:0] c, input logic [7:0] exp);
    begin
      host.xfer(c, resp);
      check("response", exp, resp);
      wait_go(1'b0, 1000);
      repeat (4) @(posedge clock);
      host.setSel(1'b1);
      @(posedge clock);
      wait_go(1'b1, 20000);
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    fail_count = fail_count + 1;
    results;
  end
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    check("proxThr", 8'h0A, {2'b00, proxThreshold});
    check("touchThr", 8'h0A, {2'b00, touchThreshold});
    repeat (180) @(posedge clock);
    check("goFloat", 8'h00, {7'h00, hostGoOe});
    repeat (100) @(posedge clock);
    check("goCal", 8'h02, {6'h00, hostGoOe, hostGo});
    wait_go(1'b1, 2000);
    cmd(8'h55, 8'h43);
    check("proxSet", 8'h15, {2'b00, proxThreshold});
    touchIn <= 1'b1;
    positionIn <= 7'h5A;
    cmd(8'hA2, 8'h43);
    check("touchSet", 8'h22, {2'b00, touchThreshold});
    b = bursts;
    cmd(8'h00, 8'hDA);
    check("nullBurst", 8'h01, 8'(bursts - b));
    touchIn <= 1'b0;
    b = bursts;
    cmd(8'h01, 8'hDA);
    check("calBursts", 8'h0A, 8'(bursts - b));
    b = drifts;
    for (i = 0; i < 10; i = i + 1) cmd(8'h03, 8'h43);
    check("drift", 8'h01, 8'(drifts - b));
    polarityErr <= 1'b0;
    cmd(8'h00, 8'h43);
    proxIn <= 1'b0;
    cmd(8'h00, 8'h41);
    b = bursts;
    host.setSel(1'b0);
    repeat (250) @(posedge clock);
    host.setSel(1'b1);
    @(posedge clock);
    wait_go(1'b0, 1400);
    wait_go(1'b1, 2000);
    check("dummyBurst", 8'h01, 8'(bursts - b));
    b = bursts;
    repeat (1500) @(posedge clock);
    check("freeRun", 8'h01, {7'h00, (bursts - b) inside {[2:4]}});
    results;
  end
endmodule // tb_touch_wheel_spi_slave_port
bind touch_wheel_spi_slave_port touch_wheel_spi_slave_port_sva #(
  .WAKE_CYC(WAKE_CYC), .BURST_CYC(BURST_CYC)
) chk (
  .clock(clock), .sys_rst(sys_rst), .sck(sck), .selectNIn(selectNIn),
  .selectNOut(selectNOut), .selectNOe(selectNOe), .misoOe(misoOe),
  .hostGo(hostGo), .hostGoOe(hostGoOe), .detectOe(detectOe),
  .burstStart(burstStart), .calibrating(calibrating),
  .proxThreshold(proxThreshold), .touchThreshold(touchThreshold)
);
